// [tpc_pkg.sv]
// constants, layouts and state type of the 16-bit timer/pwm/capture channel
// Contract
// [RQ1] control bit 19 routes the timer pin function to the alternate pin when set
// [RQ2] control bit 15 set makes the timer pin a programmable clock output
// [RQ3] control bits 14 and 13 enable the pwm waveform on outputs a and b
// [RQ4] control bits 12 and 11 invert pwm output a and b when set
// [RQ5] control bits 10..8 divide the count clock by two to that power
// [RQ6] control bit 1 picks peripheral clock (0) or timer pin input (1)
// [RQ7] control bit 7 starts the counter when set, stops it when clear
// [RQ8] control bit 6 set lets the event pin level choose up or down counting
// [RQ9] reload mode: bit 5 set makes an event pin falling edge reload the counter; the code does no such reload while bit 6 is set
// [RQ10] capture mode: bit 5 and bit 4 set, event pin fall captures into fall register
// [RQ11] bit 4 picks the falling capture source in capture mode only
// [RQ12] bit 3 set: timer pin falling edge captures count and sets fall flag
// [RQ13] bit 2 set: timer pin rising edge captures count and sets rise flag
// [RQ14] bit 0 picks reload (0) or capture (1); duty and capture share addresses
// [RQ15] count register holds the 16-bit counter, software readable and writable
// [RQ16] overflow or enabled event pin fall loads the reload value into the counter
// [RQ17] fall, rise and overflow flags set by hardware, cleared by writing one
// [RQ18] a capture register is not overwritten while its flag stays set
// [RQ19] pwm high width equals the duty value in timer clocks
// [RQ20] enable bits 6 and 5 request dma on each new fall or rise capture
// [RQ21] enable bit 4 requests dma on every overflow
// [RQ22] enable bit 3 gates the falling edge interrupt source
// [RQ23] interrupt only when flag, its own enable and master enable are all set
// [RQ24] pwm mode counts up from 0, wraps to 0 after the reload value
// [RQ25] timer up counts to 0xffff; down counts from 0xffff to the loaded value
// [RQ26] software never enables pwm capture and pwm output together
// [RQ27] reserved bits read zero and writes to them do nothing
package tpc_pkg;
    localparam logic [7:0]  TPC_OFF_CTRL   = 8'h00;
    localparam logic [7:0]  TPC_OFF_COUNT  = 8'h04;
    localparam logic [7:0]  TPC_OFF_RELOAD = 8'h08;
    localparam logic [7:0]  TPC_OFF_FLAG   = 8'h0C;
    localparam logic [7:0]  TPC_OFF_DUTY_A = 8'h10;
    localparam logic [7:0]  TPC_OFF_DUTY_B = 8'h14;
    localparam logic [7:0]  TPC_OFF_IDE    = 8'h18;

    localparam logic [31:0] TPC_CTRL_MASK  = 32'h0008_FFFF;
    localparam logic [31:0] TPC_RST_WORD   = 32'h0000_0000;
    localparam logic [15:0] TPC_CNT_MAX    = 16'hFFFF;
    localparam logic [15:0] TPC_CNT_ZERO   = 16'h0000;

    localparam int TPC_B_REMAP    = 19;
    localparam int TPC_B_CLKOUT   = 15;
    localparam int TPC_B_PWMA_EN  = 14;
    localparam int TPC_B_PWMB_EN  = 13;
    localparam int TPC_B_PWMA_INV = 12;
    localparam int TPC_B_PWMB_INV = 11;
    localparam int TPC_B_PSC_HI   = 10;
    localparam int TPC_B_PSC_LO   = 8;
    localparam int TPC_B_RUN      = 7;
    localparam int TPC_B_UPDOWN   = 6;
    localparam int TPC_B_EXT_EN   = 5;
    localparam int TPC_B_FALL_SRC = 4;
    localparam int TPC_B_FALL_EN  = 3;
    localparam int TPC_B_RISE_EN  = 2;
    localparam int TPC_B_TIMER_COUNTER_SEL    = 1;
    localparam int TPC_B_CAPMODE  = 0;

    localparam int TPC_F_FALL = 2;
    localparam int TPC_F_RISE = 1;
    localparam int TPC_F_OVF  = 0;

    localparam int TPC_E_DMA_FALL = 6;
    localparam int TPC_E_DMA_RISE = 5;
    localparam int TPC_E_DMA_OVF  = 4;
    localparam int TPC_E_IRQ_FALL = 3;
    localparam int TPC_E_IRQ_RISE = 2;
    localparam int TPC_E_IRQ_OVF  = 1;
    localparam int TPC_E_IRQ_MSTR = 0;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } tpc_bus_req_t;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [15:0] cnt;
        logic [15:0] reload_value;
        logic [15:0] duty_a;
        logic [15:0] duty_b;
        logic [15:0] rise_capture_value;
        logic [15:0] fall_capture_value;
        logic [6:0]  ide;
        logic [2:0]  flags;
        logic [6:0]  psc;
        logic        io_q;
        logic        ext_q;
        logic        clk_tog;
        logic        io_out;
        logic        io_oe;
        logic        io_alt_oe;
        logic        pwm_a;
        logic        pwm_b;
        logic        pwm_b_oe;
        logic        irq;
        logic        dma_ovf;
        logic        dma_rise;
        logic        dma_fall;
        logic [31:0] rdata;
    } tpc_state_t;
endpackage

// [tpc_timer16.sv]
// one 16-bit timer channel: prescaler, reload, pwm a/b, edge capture, dma and irq requests
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
module tpc_timer16
    import tpc_pkg::*;
#(
    parameter bit REMAP_PRESENT = 1'b1
) (
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    input  wire logic         ce_i,
    input  wire tpc_bus_req_t bus_i,
    output logic [31:0]       rdata_o,
    input  wire logic         timer_io_i,
    input  wire logic         timer_io_alt_i,
    input  wire logic         timer_ext_i,
    output logic              timer_io_o,
    output logic              timer_io_oe_o,
    output logic              timer_io_alt_oe_o,
    output logic              pwm_out_a_o,
    output logic              pwm_out_b_o,
    output logic              pwm_out_b_oe_o,
    output logic              irq_o,
    output logic              dma_ovf_req_o,
    output logic              dma_rise_req_o,
    output logic              dma_fall_req_o
);
    tpc_state_t r;
    tpc_state_t next_r;

    // duty and capture share an address; the mode bit picks which one is seen
    function automatic logic [31:0] rd_mux(input tpc_state_t s, input logic [7:0] a);
        logic [31:0] v;
        v = TPC_RST_WORD;
        unique case (a)
            TPC_OFF_CTRL:   v = s.ctrl;
            TPC_OFF_COUNT:  v = {16'h0000, s.cnt};
            TPC_OFF_RELOAD: v = {16'h0000, s.reload_value};
            TPC_OFF_FLAG:   v = {29'h0, s.flags};
            TPC_OFF_DUTY_A: v = {16'h0000, s.ctrl[TPC_B_CAPMODE] ? s.rise_capture_value : s.duty_a}; // [RQ14]
            TPC_OFF_DUTY_B: v = {16'h0000, s.ctrl[TPC_B_CAPMODE] ? s.fall_capture_value : s.duty_b}; // [RQ14]
            TPC_OFF_IDE:    v = {25'h0, s.ide};
            default:        v = TPC_RST_WORD;
        endcase
        return v;
    endfunction

    logic        io_now;
    logic        io_rise;
    logic        io_fall;
    logic        ext_fall;
    logic        src_tick;
    logic        tick;
    logic        ovf;
    logic        cap_mode;
    logic        pwm_mode;
    logic        count_down;
    logic        fall_ev;
    logic        rise_ev;
    logic        ext_reload;
    logic        wr_ok;
    logic [6:0]  psc_limit;
    logic [2:0]  flag_set;
    logic [2:0]  flag_clr;
    logic [2:0]  irq_en;
    logic [15:0] cnt_hw;

    always_comb begin
        next_r     = r;
        cap_mode   = r.ctrl[TPC_B_CAPMODE];
        // selected pin only; the other pad is left as plain input
        io_now     = (REMAP_PRESENT && r.ctrl[TPC_B_REMAP]) ? timer_io_alt_i : timer_io_i; // [RQ1]
        io_rise    = io_now & ~r.io_q;
        io_fall    = ~io_now & r.io_q;
        ext_fall   = ~timer_ext_i & r.ext_q;
        next_r.io_q  = io_now;
        next_r.ext_q = timer_ext_i;

        // prescaler counts source ticks and fires every 2^n of them
        src_tick  = r.ctrl[TPC_B_TIMER_COUNTER_SEL] ? io_rise : 1'b1; // [RQ6]
        psc_limit = 7'h7F >> (3'd7 - r.ctrl[TPC_B_PSC_HI:TPC_B_PSC_LO]); // [RQ5]
        tick      = 1'b0;
        if (r.ctrl[TPC_B_RUN] && src_tick) begin // [RQ7]
            if (r.psc >= psc_limit) begin
                next_r.psc = 7'h00;
                tick       = 1'b1;
            end else begin
                next_r.psc = r.psc + 7'h01;
            end
        end

        pwm_mode   = !cap_mode && (r.ctrl[TPC_B_PWMA_EN] || r.ctrl[TPC_B_PWMB_EN]);
        count_down = r.ctrl[TPC_B_UPDOWN] && !timer_ext_i && !pwm_mode; // [RQ8]
        ovf        = 1'b0;
        cnt_hw     = r.cnt;
        if (tick) begin
            if (pwm_mode) begin
                if (r.cnt == r.reload_value) begin // [RQ24]
                    cnt_hw = TPC_CNT_ZERO;
                    ovf    = 1'b1;
                end else begin
                    cnt_hw = r.cnt + 16'h0001;
                end
            end else if (count_down) begin
                if (r.cnt == r.reload_value) begin // [RQ25]
                    cnt_hw = TPC_CNT_MAX;
                    ovf    = 1'b1;
                end else begin
                    cnt_hw = r.cnt - 16'h0001;
                end
            end else begin
                if (r.cnt == TPC_CNT_MAX) begin // [RQ25]
                    cnt_hw = r.reload_value; // [RQ16]
                    ovf    = 1'b1;
                end else begin
                    cnt_hw = r.cnt + 16'h0001;
                end
            end
        end

        // event pin is the direction input in up/down mode, so no reload then
        ext_reload = !cap_mode && r.ctrl[TPC_B_EXT_EN] && !r.ctrl[TPC_B_UPDOWN]
                     && ext_fall; // [RQ9]
        if (ext_reload) begin
            cnt_hw = r.reload_value; // [RQ16]
        end

        fall_ev = cap_mode && (r.ctrl[TPC_B_FALL_SRC] ?
                  (r.ctrl[TPC_B_EXT_EN] && ext_fall) : // [RQ10] [RQ11]
                  (r.ctrl[TPC_B_FALL_EN] && io_fall)); // [RQ12]
        rise_ev = cap_mode && r.ctrl[TPC_B_RISE_EN] && io_rise; // [RQ13]

        flag_set         = 3'b000;
        flag_set[TPC_F_OVF] = ovf;
        next_r.dma_ovf   = ovf && r.ide[TPC_E_DMA_OVF]; // [RQ21]
        next_r.dma_fall  = 1'b0;
        next_r.dma_rise  = 1'b0;
        if (ext_reload) begin
            flag_set[TPC_F_FALL] = 1'b1;
        end
        // a pending flag protects the captured value until software acks it
        if (fall_ev && !r.flags[TPC_F_FALL]) begin // [RQ18]
            next_r.fall_capture_value          = r.cnt;
            flag_set[TPC_F_FALL] = 1'b1;
            next_r.dma_fall      = r.ide[TPC_E_DMA_FALL]; // [RQ20]
        end
        if (rise_ev && !r.flags[TPC_F_RISE]) begin // [RQ18]
            next_r.rise_capture_value          = r.cnt;
            flag_set[TPC_F_RISE] = 1'b1;
            next_r.dma_rise      = r.ide[TPC_E_DMA_RISE]; // [RQ20]
        end

        next_r.cnt = cnt_hw;
        flag_clr   = 3'b000;
        wr_ok      = bus_i.wr;
        if (wr_ok) begin
            unique case (bus_i.addr)
                TPC_OFF_CTRL:   next_r.ctrl = bus_i.wdata & TPC_CTRL_MASK; // [RQ27]
                TPC_OFF_COUNT:  next_r.cnt  = bus_i.wdata[15:0]; // [RQ15]
                TPC_OFF_RELOAD: next_r.reload_value  = bus_i.wdata[15:0];
                TPC_OFF_FLAG:   flag_clr    = bus_i.wdata[2:0];
                TPC_OFF_DUTY_A: begin
                    if (cap_mode) begin
                        next_r.rise_capture_value = bus_i.wdata[15:0]; // [RQ14]
                    end else begin
                        next_r.duty_a = bus_i.wdata[15:0];
                    end
                end
                TPC_OFF_DUTY_B: begin
                    if (cap_mode) begin
                        next_r.fall_capture_value = bus_i.wdata[15:0]; // [RQ14]
                    end else begin
                        next_r.duty_b = bus_i.wdata[15:0];
                    end
                end
                TPC_OFF_IDE:    next_r.ide = bus_i.wdata[6:0]; // [RQ27]
                default: ;
            endcase
        end
        // set beats a same-cycle clear so no event is lost
        next_r.flags = (r.flags & ~flag_clr) | flag_set; // [RQ17]

        irq_en = {r.ide[TPC_E_IRQ_FALL], r.ide[TPC_E_IRQ_RISE], r.ide[TPC_E_IRQ_OVF]}; // [RQ22]
        next_r.irq = r.ide[TPC_E_IRQ_MSTR] && |(r.flags & irq_en); // [RQ23]

        // high while count is below duty: high width is exactly duty ticks
        next_r.pwm_a = r.ctrl[TPC_B_PWMA_EN] && !cap_mode &&
                       ((r.cnt < r.duty_a) ^ r.ctrl[TPC_B_PWMA_INV]); // [RQ3] [RQ4] [RQ19]
        next_r.pwm_b = r.ctrl[TPC_B_PWMB_EN] && !cap_mode &&
                       ((r.cnt < r.duty_b) ^ r.ctrl[TPC_B_PWMB_INV]); // [RQ3] [RQ4] [RQ19]
        next_r.pwm_b_oe = r.ctrl[TPC_B_PWMB_EN] && !cap_mode; // [RQ3]

        if (ovf) begin
            next_r.clk_tog = ~r.clk_tog;
        end
        next_r.io_out = r.ctrl[TPC_B_CLKOUT] ? r.clk_tog : next_r.pwm_a; // [RQ2]
        next_r.io_oe  = r.ctrl[TPC_B_CLKOUT] ||
                        (r.ctrl[TPC_B_PWMA_EN] && !cap_mode); // [RQ2] [RQ3]
        next_r.io_alt_oe = next_r.io_oe && REMAP_PRESENT && r.ctrl[TPC_B_REMAP]; // [RQ1]
        if (next_r.io_alt_oe) begin
            next_r.io_oe = 1'b0;
        end

        next_r.rdata = bus_i.rd ? rd_mux(r, bus_i.addr) : TPC_RST_WORD; // [RQ27]
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r <= '0;
        end else if (ce_i) begin
            r <= next_r;
        end
    end

    assign rdata_o           = r.rdata;
    assign timer_io_o        = r.io_out;
    assign timer_io_oe_o     = r.io_oe;
    assign timer_io_alt_oe_o = r.io_alt_oe;
    assign pwm_out_a_o       = r.pwm_a;
    assign pwm_out_b_o       = r.pwm_b;
    assign pwm_out_b_oe_o    = r.pwm_b_oe;
    assign irq_o             = r.irq;
    assign dma_ovf_req_o     = r.dma_ovf;
    assign dma_rise_req_o    = r.dma_rise;
    assign dma_fall_req_o    = r.dma_fall;
endmodule

// [tpc_pin_model.sv]
// far-side pins: timer pin, alternate pin and event pin
`timescale 1ns/100ps
module tpc_pin_model (
    input  wire logic io_lvl_i,
    input  wire logic ext_lvl_i,
    input  wire logic io_drv_i,
    input  wire logic io_oe_i,
    input  wire logic alt_oe_i,
    output logic      io_o,
    output logic      alt_o,
    output logic      ext_o
);
    // a driven pin shows the channel's level, else the source's
    assign io_o  = io_oe_i ? io_drv_i : io_lvl_i;
    // idle alternate pin carries the inverse, never a stale copy
    assign alt_o = alt_oe_i ? io_drv_i : !io_lvl_i;
    assign ext_o = ext_lvl_i;
endmodule

// [tpc_timer16_props.sv]
// port assertions for the timer channel
`timescale 1ns/100ps
module tpc_timer16_props
    import tpc_pkg::*;
(
    input wire logic         clk_i,
    input wire logic         resetn_i,
    input wire logic         ce_i,
    input wire tpc_bus_req_t bus_i,
    input wire logic [31:0]  rdata_o,
    input wire logic         timer_io_oe_o,
    input wire logic         timer_io_alt_oe_o,
    input wire logic         pwm_out_a_o,
    input wire logic         pwm_out_b_oe_o,
    input wire logic         irq_o,
    input wire logic         dma_ovf_req_o,
    input wire logic         dma_rise_req_o,
    input wire logic         dma_fall_req_o
);
    logic [15:0] ctl;
    logic [6:0]  ide;
    // shadow of control and enable words, updated like the registers
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctl <= 16'h0000;
            ide <= 7'h00;
        end else if (ce_i && bus_i.wr) begin
            if (bus_i.addr == TPC_OFF_CTRL) ctl <= bus_i.wdata[15:0];
            if (bus_i.addr == TPC_OFF_IDE) ide <= bus_i.wdata[6:0];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    a_rdata_idle: assert property ((ce_i && !bus_i.rd) |=> rdata_o == 32'h0000_0000)
        else $error("read data not zero after idle cycle");
    a_oe_onehot: assert property (!(timer_io_oe_o && timer_io_alt_oe_o))
        else $error("both timer pins driven");
    a_pwma_off: assert property ($past(!ctl[14] || ctl[0]) |-> !pwm_out_a_o)
        else $error("pwm a active while disabled");
    a_pwmb_oe: assert property (pwm_out_b_oe_o |-> $past(ctl[13] && !ctl[0]))
        else $error("pwm b enabled without its bit");
    a_ovf_dma: assert property (dma_ovf_req_o |-> $past(ide[4] && ctl[7]))
        else $error("overflow dma without enable or run");
    a_rise_dma: assert property (dma_rise_req_o |-> $past(ide[5] && ctl[0]))
        else $error("rise dma without enable");
    a_fall_dma: assert property (dma_fall_req_o |-> $past(ide[6] && ctl[0]))
        else $error("fall dma without enable");
    a_irq_master: assert property (irq_o |-> $past(ide[0]))
        else $error("irq without master enable");
    a_rise_once: assert property (dma_rise_req_o |=> !dma_rise_req_o)
        else $error("rise capture repeated while flag set");
    c_ovf: cover property (dma_ovf_req_o);
    c_rise: cover property (dma_rise_req_o);
    c_irq: cover property (irq_o);
endmodule
bind tpc_timer16 tpc_timer16_props chk_u (.clk_i, .resetn_i, .ce_i, .bus_i, .rdata_o,
    .timer_io_oe_o, .timer_io_alt_oe_o, .pwm_out_a_o, .pwm_out_b_oe_o, .irq_o,
    .dma_ovf_req_o, .dma_rise_req_o, .dma_fall_req_o);

// [tb.sv]
// self-checking bench for the timer channel
`timescale 1ns/100ps
module tb;
    import tpc_pkg::*;
    logic         clk_i = 1'b0;
    logic         resetn_i = 1'b0;
    tpc_bus_req_t bus_i = '0;
    logic         io_lvl = 1'b0;
    logic         ext_lvl = 1'b1;
    logic [31:0]  rdata_o;
    logic [31:0]  rd_v;
    logic         io_pin, alt_pin, ext_pin, io_drv, io_oe, alt_oe, pwm_a, irq;
    logic         d_ovf, d_rise, d_fall;
    logic         ce = 1'b1;
    logic         pwm_b, pwm_b_oe;
    int           error_cnt = 0;
    int           n_tests = 0;
    int           n_ovf = 0;
    int           n_rise = 0;
    int           n_fall = 0;
    int           n_pwm = 0;
    int           b;
    int           c;
    int           n_pwmb = 0;
    int           n_alt = 0;
    always #2 clk_i = ~clk_i;
    // counted by nba so a task reading at an edge sees a settled total
    always @(posedge clk_i) begin
        n_ovf  <= n_ovf + int'(d_ovf);
        n_rise <= n_rise + int'(d_rise);
        n_fall <= n_fall + int'(d_fall);
        n_pwm  <= n_pwm + int'(pwm_a);
        n_pwmb <= n_pwmb + int'(pwm_b);
        n_alt  <= n_alt + int'(alt_pin);
    end
    tpc_pin_model pin_u (.io_lvl_i(io_lvl), .ext_lvl_i(ext_lvl), .io_drv_i(io_drv),
        .io_oe_i(io_oe), .alt_oe_i(alt_oe), .io_o(io_pin), .alt_o(alt_pin), .ext_o(ext_pin));
    tpc_timer16 dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce), .bus_i(bus_i),
        .rdata_o(rdata_o), .timer_io_i(io_pin), .timer_io_alt_i(alt_pin),
        .timer_ext_i(ext_pin), .timer_io_o(io_drv), .timer_io_oe_o(io_oe),
        .timer_io_alt_oe_o(alt_oe), .pwm_out_a_o(pwm_a), .pwm_out_b_o(pwm_b),
        .pwm_out_b_oe_o(pwm_b_oe), .irq_o(irq), .dma_ovf_req_o(d_ovf),
        .dma_rise_req_o(d_rise), .dma_fall_req_o(d_fall));
    task test_done();
        if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        bus_i.addr  <= a;
        bus_i.wdata <= d;
        bus_i.wr    <= 1'b1;
        @(posedge clk_i);
        bus_i.wr    <= 1'b0;
    endtask
    // read data is taken at the next edge, before it updates
    task rdc(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i);
        bus_i.addr <= a;
        bus_i.rd   <= 1'b1;
        @(posedge clk_i);
        bus_i.rd   <= 1'b0;
        @(posedge clk_i);
        chk(rdata_o, e);
    endtask
    task t_regs();
        for (int a = 0; a < 32; a += 4) rdc(8'(a), 32'h0000_0000);
        wr(TPC_OFF_CTRL, 32'hFFFF_FF7E);
        rdc(TPC_OFF_CTRL, 32'h0008_FF7E);
        wr(TPC_OFF_CTRL, 32'h0000_0000);
        wr(TPC_OFF_IDE, 32'hFFFF_FF80);
        rdc(TPC_OFF_IDE, 32'h0000_0000);
        wr(TPC_OFF_COUNT, 32'hABCD_1234);
        rdc(TPC_OFF_COUNT, 32'h0000_1234);
        wr(8'h1C, 32'hFFFF_FFFF);
        rdc(8'h1C, 32'h0000_0000);
    endtask
    task t_pwm();
        wr(TPC_OFF_COUNT, 32'h0000_0000);
        wr(TPC_OFF_RELOAD, 32'h0000_0003);
        wr(TPC_OFF_DUTY_A, 32'h0000_0001);
        wr(TPC_OFF_IDE, 32'h0000_0013);
        wr(TPC_OFF_CTRL, 32'h0000_4080);
        cyc(8);
        b = n_pwm;
        cyc(40);
        chk(n_pwm - b, 10);
        chk({31'h0, irq}, 32'h1);
        b = n_ovf;
        wr(TPC_OFF_CTRL, 32'h0000_5080);
        cyc(6);
        chk(n_ovf - b, 2);
        b = n_pwm;
        cyc(40);
        chk(n_pwm - b, 30);
        wr(TPC_OFF_IDE, 32'h0000_0012);
        cyc(2);
        chk({31'h0, irq}, 32'h0);
        wr(TPC_OFF_CTRL, 32'h0000_0000);
        rdc(TPC_OFF_FLAG, 32'h0000_0001);
        wr(TPC_OFF_FLAG, 32'h0000_0001);
        rdc(TPC_OFF_FLAG, 32'h0000_0000);
    endtask
    // a run spans cyc(n)+2 counting edges, so 128 edges divide every prescale
    task t_psc();
        for (int p = 0; p < 8; p++) begin
            wr(TPC_OFF_COUNT, 32'h0000_0000);
            wr(TPC_OFF_CTRL, 32'h0000_0080 | (p << 8));
            cyc(126);
            wr(TPC_OFF_CTRL, 32'h0000_0000);
            cyc(4);
            rdc(TPC_OFF_COUNT, 32'd128 >> p);
        end
        wr(TPC_OFF_RELOAD, 32'h0000_0010);
        wr(TPC_OFF_COUNT, 32'h0000_FFFE);
        wr(TPC_OFF_CTRL, 32'h0000_0080);
        cyc(1);
        wr(TPC_OFF_CTRL, 32'h0000_0000);
        rdc(TPC_OFF_COUNT, 32'h0000_0011);
        rdc(TPC_OFF_FLAG, 32'h0000_0001);
        wr(TPC_OFF_FLAG, 32'h0000_0001);
        wr(TPC_OFF_COUNT, 32'h0000_0000);
        wr(TPC_OFF_CTRL, 32'h0000_0082);
        for (int i = 0; i < 5; i++) begin
            io_lvl <= 1'b1;
            cyc(3);
            io_lvl <= 1'b0;
            cyc(3);
        end
        wr(TPC_OFF_CTRL, 32'h0000_0000);
        rdc(TPC_OFF_COUNT, 32'h0000_0005);
    endtask
    // counter held still so each capture value is known exactly
    task t_cap();
        wr(TPC_OFF_IDE, 32'h0000_0060);
        wr(TPC_OFF_COUNT, 32'h0000_1234);
        wr(TPC_OFF_CTRL, 32'h0000_0035);
        io_lvl <= 1'b1;
        cyc(4);
        wr(TPC_OFF_COUNT, 32'h0000_5678);
        io_lvl <= 1'b0;
        cyc(3);
        io_lvl <= 1'b1;
        cyc(4);
        rdc(TPC_OFF_FLAG, 32'h0000_0002);
        rdc(TPC_OFF_DUTY_A, 32'h0000_1234);
        ext_lvl <= 1'b0;
        cyc(4);
        rdc(TPC_OFF_FLAG, 32'h0000_0006);
        rdc(TPC_OFF_DUTY_B, 32'h0000_5678);
        wr(TPC_OFF_FLAG, 32'h0000_0007);
        rdc(TPC_OFF_FLAG, 32'h0000_0000);
        io_lvl <= 1'b0;
        cyc(3);
        io_lvl <= 1'b1;
        cyc(4);
        rdc(TPC_OFF_DUTY_A, 32'h0000_5678);
        chk(n_rise, 2);
        chk(n_fall, 1);
        ext_lvl <= 1'b1;
        wr(TPC_OFF_RELOAD, 32'h0000_0042);
        wr(TPC_OFF_CTRL, 32'h0000_0020);
        ext_lvl <= 1'b0;
        cyc(4);
        rdc(TPC_OFF_COUNT, 32'h0000_0042);
    endtask
    // direction and wrap, pin-fall capture, pwm b, clock out on remapped pin, clock enable
    task t_misc();
        wr(TPC_OFF_COUNT, 32'h0000_000A);
        wr(TPC_OFF_RELOAD, 32'h0000_0008);
        wr(TPC_OFF_CTRL, 32'h0000_00C0);
        cyc(2);
        wr(TPC_OFF_CTRL, 32'h0000_0000);
        rdc(TPC_OFF_COUNT, 32'h0000_FFFE);
        ext_lvl <= 1'b1;
        wr(TPC_OFF_CTRL, 32'h0000_00C0);
        cyc(2);
        wr(TPC_OFF_CTRL, 32'h0000_0000);
        rdc(TPC_OFF_COUNT, 32'h0000_000A);
        wr(TPC_OFF_FLAG, 32'h0000_0007);
        wr(TPC_OFF_IDE, 32'h0000_0009);
        wr(TPC_OFF_CTRL, 32'h0000_0009);
        io_lvl <= 1'b0;
        cyc(4);
        rdc(TPC_OFF_FLAG, 32'h0000_0004);
        rdc(TPC_OFF_DUTY_B, 32'h0000_000A);
        chk({31'h0, irq}, 32'h1);
        wr(TPC_OFF_IDE, 32'h0000_0001);
        cyc(2);
        chk({31'h0, irq}, 32'h0);
        wr(TPC_OFF_CTRL, 32'h0000_0000);
        wr(TPC_OFF_COUNT, 32'h0000_0000);
        wr(TPC_OFF_RELOAD, 32'h0000_0003);
        wr(TPC_OFF_DUTY_B, 32'h0000_0002);
        wr(TPC_OFF_CTRL, 32'h0008_A080);
        cyc(8);
        b = n_pwmb;
        c = n_alt;
        cyc(40);
        chk(n_pwmb - b, 20);
        chk(n_alt - c, 20);
        chk({29'h0, io_oe, alt_oe, pwm_b_oe}, 32'h3);
        wr(TPC_OFF_CTRL, 32'h0000_0000);
        wr(TPC_OFF_COUNT, 32'h0000_0000);
        wr(TPC_OFF_CTRL, 32'h0000_0080);
        // ten frozen edges must add nothing to the count
        ce <= 1'b0;
        cyc(10);
        ce <= 1'b1;
        wr(TPC_OFF_CTRL, 32'h0000_0000);
        rdc(TPC_OFF_COUNT, 32'h0000_0002);
    endtask
    initial begin
        cyc(20);
        resetn_i <= 1'b1;
        t_regs();
        t_pwm();
        t_psc();
        t_cap();
        t_misc();
        test_done();
    end
    initial begin
        #50000;
        error_cnt++;
        test_done();
    end
endmodule
